/* File: hdl/isdc_pkg.sv */
package isdc_pkg;

  localparam int unsigned CLK_NS        = 5;
  localparam int unsigned BASE_FAST_NS  = 610350;
  localparam int unsigned BASE_SLOW_NS  = 18921000;
  localparam int unsigned MS_NS         = 1000000;
  localparam int unsigned BASE_FAST_CYC = BASE_FAST_NS / CLK_NS;
  localparam int unsigned BASE_SLOW_CYC = BASE_SLOW_NS / CLK_NS;
  localparam int unsigned MS_CYC        = MS_NS / CLK_NS;
  localparam int unsigned FLASH_MS      = 50;
  localparam int unsigned PNULL_S       = 30;
  localparam int unsigned PNULL_MS      = PNULL_S * 1000;
  localparam int unsigned SLEEP_LSB_MS  = 500;

  localparam logic [6:0] A_SUPPLY = 7'h02;
  localparam logic [6:0] A_GYRO   = 7'h04;
  localparam logic [6:0] A_XACC   = 7'h0A;
  localparam logic [6:0] A_YACC   = 7'h0C;
  localparam logic [6:0] A_ZACC   = 7'h0E;
  localparam logic [6:0] A_TEMP   = 7'h10;
  localparam logic [6:0] A_PITCH  = 7'h12;
  localparam logic [6:0] A_ROLL   = 7'h14;
  localparam logic [6:0] A_AUX    = 7'h16;
  localparam logic [6:0] A_GOFF   = 7'h1A;
  localparam logic [6:0] A_XOFF   = 7'h20;
  localparam logic [6:0] A_YOFF   = 7'h22;
  localparam logic [6:0] A_ZOFF   = 7'h24;
  localparam logic [6:0] A_DAC    = 7'h30;
  localparam logic [6:0] A_MISC   = 7'h34;
  localparam logic [6:0] A_SMPL   = 7'h36;
  localparam logic [6:0] A_SLP    = 7'h3A;
  localparam logic [6:0] A_DIAG   = 7'h3C;
  localparam logic [6:0] A_CMD    = 7'h3E;

  localparam int unsigned CMD_NULL    = 0;
  localparam int unsigned CMD_RESTORE = 1;
  localparam int unsigned CMD_DAC     = 2;
  localparam int unsigned CMD_FLASH   = 3;
  localparam int unsigned CMD_PNULL   = 4;
  localparam int unsigned CMD_SWRST   = 7;
  localparam int unsigned MISC_LINC   = 7;
  localparam int unsigned SMPL_BASE   = 7;
  localparam int unsigned SLP_FOREVER = 8;
  localparam logic [7:0]  LOWPWR_MIN  = 8'h0A;
  localparam logic [3:0]  BURST_LEN   = 4'h9;

  localparam logic [15:0] MISC_RST = 16'h0006;
  localparam logic [7:0]  SMPL_RST = 8'h01;

  typedef struct packed {
    logic [12:0] goff;
    logic [11:0] xoff;
    logic [11:0] yoff;
    logic [11:0] zoff;
    logic [15:0] misc;
    logic [7:0]  smpl;
  } isdc_cfg_t;

  localparam isdc_cfg_t CFG_RST = '{goff: 13'h0000, xoff: 12'h000, yoff: 12'h000,
                                    zoff: 12'h000, misc: MISC_RST, smpl: SMPL_RST};

  typedef struct packed {
    logic [13:0] rate;
    logic [13:0] ax;
    logic [13:0] ay;
    logic [13:0] az;
    logic [11:0] temp;
    logic [11:0] supply;
    logic [11:0] aux;
    logic [12:0] roll;
    logic [12:0] pitch;
    logic [13:0] lin_corr;
    logic [1:0]  range_sel;
    logic [15:0] diag;
  } isdc_front_t;

endpackage : isdc_pkg

/* File: hdl/isdc_spi_link.sv */
`timescale 1ns/10ps
module isdc_spi_link (
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic        mosi_i,
  input  wire logic [15:0] tx_word_i,
  output logic      [15:0] rx_word_o,
  output logic             rx_toggle_o,
  output logic             miso_o
);
  typedef struct packed {
    logic [14:0] sr;
    logic [3:0]  cnt;
    logic [15:0] rx;
    logic        tog;
  } isdc_lnk_t;

  isdc_lnk_t   r_q;
  isdc_lnk_t   r_d;
  logic [15:0] out_q;

  // mode 3: sample on rising edge, frame ends after the 16th bit
  // done level: high from frame end until the next frame's first bit
  always_comb begin
    r_d = r_q;
    if (cs_n_i) begin
      r_d.cnt = 4'h0;
      r_d.tog = 1'b0;
    end else begin
      r_d.sr  = {r_q.sr[13:0], mosi_i};
      r_d.cnt = r_q.cnt + 4'h1;
      if (r_q.cnt == 4'h0) begin
        r_d.tog = 1'b0;
      end
      if (r_q.cnt == 4'hF) begin
        r_d.rx  = {r_q.sr, mosi_i};
        r_d.tog = 1'b1;
      end
    end
  end

  always_ff @(posedge sclk_i) begin
    r_q <= r_d;
  end

  // answer word is held steady by the core between frames; load on first fall
  always_ff @(negedge sclk_i) begin
    if (!cs_n_i) begin
      if (r_q.cnt == 4'h0) begin
        out_q <= tx_word_i;
      end else begin
        out_q <= {out_q[14:0], 1'b0};
      end
    end
  end

  assign rx_word_o   = r_q.rx;
  assign rx_toggle_o = r_q.tog;
  assign miso_o      = out_q[15];

endmodule : isdc_spi_link

/* File: hdl/isdc_core.sv */
`timescale 1ns/10ps
module isdc_core
  import isdc_pkg::*;
#(
  parameter int unsigned BASE_FAST_CYCLES = BASE_FAST_CYC,
  parameter int unsigned BASE_SLOW_CYCLES = BASE_SLOW_CYC,
  parameter int unsigned MS_CYCLES        = MS_CYC,
  parameter int unsigned STARTUP_MS       = 1
) (
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  input  wire logic               sclk_i,
  input  wire logic               cs_n_i,
  input  wire logic               mosi_i,
  input  wire isdc_pkg::isdc_front_t fe_i,
  output logic                    miso_o,
  output logic                    miso_oe_n_o,
  output logic [11:0]             dac_level_o,
  output logic                    low_power_o,
  output logic                    sleeping_o,
  output logic                    offline_o
);
  import isdc_pkg::*;

  if (BASE_FAST_CYCLES < 1 || BASE_SLOW_CYCLES < 1 || BASE_FAST_CYCLES >= (1 << 22) ||
      BASE_SLOW_CYCLES >= (1 << 22) || MS_CYCLES < 1 || MS_CYCLES >= (1 << 18) ||
      STARTUP_MS >= (1 << 17)) begin : g_bad
    $error("isdc_core: count parameter out of range");
  end

  typedef enum logic [4:0] {
    ST_RUN   = 5'b00001,
    ST_FLASH = 5'b00010,
    ST_PNULL = 5'b00100,
    ST_START = 5'b01000,
    ST_SLEEP = 5'b10000
  } isdc_st_t;

  typedef struct packed {
    logic [2:0]  cs_s;
    logic        cs_acc;
    logic [2:0]  tg_s;
    logic        tg_acc;
    isdc_st_t    st;
    logic [17:0] pre;
    logic [16:0] ms;
    logic [21:0] bcnt;
    logic [6:0]  ncnt;
    isdc_cfg_t   cfg;
    isdc_cfg_t   fl;
    logic [11:0] dac;
    logic [11:0] dac_in;
    logic [8:0]  slp;
    logic        slp_go;
    logic [7:0]  cmd;
    logic [7:0]  cur;
    logic [13:0] gy;
    logic [13:0] ax;
    logic [13:0] ay;
    logic [13:0] az;
    logic [11:0] sup;
    logic [11:0] tmp;
    logic [11:0] aux;
    logic [12:0] roll;
    logic [12:0] pitch;
    logic        nd;
    logic [13:0] pacc;
    logic [3:0]  burst;
    logic [15:0] tx;
    logic        oe_n;
    logic        lp;
    logic        offl;
    logic        sl;
  } isdc_state_t;

  isdc_state_t r_q;
  isdc_state_t r_d;
  logic [15:0] rx_word;
  logic        rx_tog;

  isdc_spi_link u_link (
    .sclk_i      (sclk_i),
    .cs_n_i      (cs_n_i),
    .mosi_i      (mosi_i),
    .tx_word_i   (r_q.tx),
    .rx_word_o   (rx_word),
    .rx_toggle_o (rx_tog),
    .miso_o      (miso_o)
  );

  function automatic logic [15:0] wb(input logic [15:0] old, input logic hi,
                                     input logic [7:0] b);
    wb = hi ? {b, old[7:0]} : {old[15:8], b};
  endfunction : wb

  function automatic logic [6:0] blist(input logic [3:0] i);
    case (i)
      4'h0:    blist = A_SUPPLY;
      4'h1:    blist = A_GYRO;
      4'h2:    blist = A_XACC;
      4'h3:    blist = A_YACC;
      4'h4:    blist = A_ZACC;
      4'h5:    blist = A_TEMP;
      4'h6:    blist = A_PITCH;
      4'h7:    blist = A_ROLL;
      default: blist = A_AUX;
    endcase
  endfunction : blist

  function automatic logic is_out(input logic [6:0] a);
    is_out = ({a[6:1], 1'b0} >= A_SUPPLY) && ({a[6:1], 1'b0} <= A_AUX);
  endfunction : is_out

  function automatic logic [15:0] rd(input logic [6:0] a, input isdc_state_t s,
                                     input logic [15:0] diag);
    logic ea;
    ea = |diag;
    case ({a[6:1], 1'b0})
      A_SUPPLY: rd = {s.nd, ea, 2'b00, s.sup};
      A_GYRO:   rd = {s.nd, ea, s.gy};
      A_XACC:   rd = {s.nd, ea, s.ax};
      A_YACC:   rd = {s.nd, ea, s.ay};
      A_ZACC:   rd = {s.nd, ea, s.az};
      A_TEMP:   rd = {s.nd, ea, {2{s.tmp[11]}}, s.tmp};
      A_PITCH:  rd = {s.nd, ea, s.pitch[12], s.pitch};
      A_ROLL:   rd = {s.nd, ea, s.roll[12], s.roll};
      A_AUX:    rd = {s.nd, ea, 2'b00, s.aux};
      A_GOFF:   rd = {3'b000, s.cfg.goff};
      A_XOFF:   rd = {4'h0, s.cfg.xoff};
      A_YOFF:   rd = {4'h0, s.cfg.yoff};
      A_ZOFF:   rd = {4'h0, s.cfg.zoff};
      A_DAC:    rd = {4'h0, s.dac};
      A_MISC:   rd = s.cfg.misc;
      A_SMPL:   rd = {8'h00, s.cfg.smpl};
      A_DIAG:   rd = diag;
      default:  rd = 16'h0000;
    endcase
  endfunction : rd

  always_comb begin
    logic        cs_fall;
    logic        fr;
    logic        tick_ms;
    logic        ms_done;
    logic        btick;
    logic        stick;
    logic        rdo;
    logic        upd;
    logic        zero;
    logic [21:0] base;
    logic [1:0]  sh;
    logic [15:0] gw;
    logic signed [15:0] tw;
    logic [15:0] lc;
    logic [15:0] gsum;
    logic [13:0] pdel;
    logic [6:0]  wa;
    logic [6:0]  ra;
    logic [15:0] w;
    r_d     = r_q;
    cs_fall = 1'b0;
    fr      = 1'b0;
    rdo     = 1'b0;
    upd     = 1'b0;
    zero    = 1'b0;
    stick   = 1'b0;
    w       = rx_word;
    wa      = {1'b0, w[13:9], 1'b0};
    ra      = w[14:8];
    pdel    = 14'h0000;
    tick_ms = 1'b0;
    ms_done = 1'b0;
    btick   = 1'b0;
    base    = 22'h000000;
    sh      = 2'h0;
    gw      = 16'h0000;
    tw      = 16'sh0000;
    lc      = 16'h0000;
    gsum    = 16'h0000;

    // link events: three-stage sync, accepted once stages two and three agree
    r_d.cs_s = {r_q.cs_s[1:0], cs_n_i};
    if (r_q.cs_s[1] == r_q.cs_s[2] && r_q.cs_s[2] != r_q.cs_acc) begin
      r_d.cs_acc = r_q.cs_s[2];
      cs_fall    = ~r_q.cs_s[2];
    end
    r_d.tg_s = {r_q.tg_s[1:0], rx_tog};
    if (r_q.tg_s[1] == r_q.tg_s[2] && r_q.tg_s[2] != r_q.tg_acc) begin
      r_d.tg_acc = r_q.tg_s[2];
      fr         = r_q.tg_s[2];
    end

    // millisecond time base for long operations
    tick_ms = (r_q.pre == 18'(MS_CYCLES - 1));
    r_d.pre = tick_ms ? 18'h00000 : r_q.pre + 18'h00001;
    ms_done = (r_q.ms == 17'h00000);
    if (tick_ms && !ms_done) begin
      r_d.ms = r_q.ms - 17'h00001;
    end

    // sample timer, halted while asleep
    base = r_q.cfg.smpl[SMPL_BASE] ? 22'(BASE_SLOW_CYCLES) : 22'(BASE_FAST_CYCLES);
    btick = (r_q.bcnt >= base - 22'h000001);
    if (r_q.st == ST_SLEEP) begin
      r_d.bcnt = 22'h000000;
      r_d.ncnt = 7'h00;
    end else begin
      r_d.bcnt = btick ? 22'h000000 : r_q.bcnt + 22'h000001;
      if (btick) begin
        if (r_q.ncnt >= r_q.cfg.smpl[6:0]) begin
          r_d.ncnt = 7'h00;
          stick    = 1'b1;
        end else begin
          r_d.ncnt = r_q.ncnt + 7'h01;
        end
      end
    end

    // rate path: range scaling, trim and optional acceleration correction
    sh   = (fe_i.range_sel > 2'd2) ? 2'd2 : fe_i.range_sel;
    gw   = {{2{fe_i.rate[13]}}, fe_i.rate} << sh;
    tw   = $signed({{3{r_q.cfg.goff[12]}}, r_q.cfg.goff}) >>> (2'd2 - sh);
    lc   = r_q.cfg.misc[MISC_LINC] ? {{2{fe_i.lin_corr[13]}}, fe_i.lin_corr} : 16'h0000;
    gsum = gw + tw - lc;

    case (r_q.st)
      ST_RUN: begin
        if (stick) begin
          upd       = 1'b1;
          r_d.gy    = gsum[13:0];
          r_d.ax    = fe_i.ax + {{2{r_q.cfg.xoff[11]}}, r_q.cfg.xoff};
          r_d.ay    = fe_i.ay + {{2{r_q.cfg.yoff[11]}}, r_q.cfg.yoff};
          r_d.az    = fe_i.az + {{2{r_q.cfg.zoff[11]}}, r_q.cfg.zoff};
          r_d.sup   = fe_i.supply;
          r_d.tmp   = fe_i.temp;
          r_d.aux   = fe_i.aux;
          r_d.roll  = fe_i.roll;
          r_d.pitch = fe_i.pitch;
        end
        if (r_q.cmd[CMD_SWRST]) begin
          r_d.cfg = r_q.fl;
          zero    = 1'b1;
          r_d.cur = 8'h80;
          r_d.st  = ST_START;
          r_d.ms  = 17'(STARTUP_MS);
        end else if (r_q.cmd[CMD_NULL]) begin
          r_d.cfg.goff = r_q.cfg.goff - {r_q.gy[10:0], 2'b00};
          zero         = 1'b1;
          r_d.cur      = 8'h01;
          r_d.st       = ST_FLASH;
          r_d.ms       = 17'(FLASH_MS);
        end else if (r_q.cmd[CMD_PNULL]) begin
          r_d.pacc = 14'h0000;
          r_d.cur  = 8'h10;
          r_d.st   = ST_PNULL;
          r_d.ms   = 17'(PNULL_MS);
        end else if (r_q.cmd[CMD_RESTORE]) begin
          r_d.cfg.goff = 13'h0000;
          r_d.cfg.xoff = 12'h000;
          r_d.cfg.yoff = 12'h000;
          r_d.cfg.zoff = 12'h000;
          zero         = 1'b1;
          r_d.cur      = 8'h02;
          r_d.st       = ST_FLASH;
          r_d.ms       = 17'(FLASH_MS);
        end else if (r_q.cmd[CMD_FLASH]) begin
          r_d.cur = 8'h08;
          r_d.st  = ST_FLASH;
          r_d.ms  = 17'(FLASH_MS);
        end else if (r_q.cmd[CMD_DAC]) begin
          r_d.dac_in       = r_q.dac;
          r_d.cmd[CMD_DAC] = 1'b0;
        end else if (r_q.slp_go) begin
          r_d.slp_go = 1'b0;
          if (r_q.slp[SLP_FOREVER]) begin
            r_d.st = ST_SLEEP;
          end else if (r_q.slp[7:0] != 8'h00) begin
            r_d.st = ST_SLEEP;
            r_d.ms = 17'(r_q.slp[7:0] * 17'(SLEEP_LSB_MS));
          end
        end
      end
      ST_FLASH: begin
        if (ms_done) begin
          r_d.fl  = r_q.cfg;
          r_d.cmd = r_q.cmd & ~r_q.cur;
          r_d.st  = ST_RUN;
        end
      end
      ST_PNULL: begin
        if (stick) begin
          pdel     = fe_i.rate - r_q.pacc;
          r_d.pacc = r_q.pacc + {{3{pdel[13]}}, pdel[13:3]};
        end
        if (ms_done) begin
          r_d.cfg.goff = 13'h0000 - {r_q.pacc[10:0], 2'b00};
          zero         = 1'b1;
          r_d.st       = ST_FLASH;
          r_d.ms       = 17'(FLASH_MS);
        end
      end
      ST_START: begin
        if (ms_done) begin
          r_d.cmd = r_q.cmd & ~r_q.cur;
          r_d.st  = ST_RUN;
        end
      end
      ST_SLEEP: begin
        if (r_q.slp[SLP_FOREVER] ? cs_fall : ms_done) begin
          r_d.slp = 9'h000;
          r_d.st  = ST_RUN;
        end
      end
      default: r_d.st = ST_RUN;
    endcase

    if (zero) begin
      r_d.gy    = 14'h0000;
      r_d.ax    = 14'h0000;
      r_d.ay    = 14'h0000;
      r_d.az    = 14'h0000;
      r_d.sup   = 12'h000;
      r_d.tmp   = 12'h000;
      r_d.aux   = 12'h000;
      r_d.roll  = 13'h0000;
      r_d.pitch = 13'h0000;
    end

    // frame decode after the sequencer so host writes win over self-clears
    if (fr) begin
      if (r_q.burst != 4'h0 && r_q.burst != BURST_LEN) begin
        r_d.tx    = rd(blist(r_q.burst), r_q, fe_i.diag);
        r_d.burst = r_q.burst + 4'h1;
        rdo       = 1'b1;
      end else begin
        r_d.burst = 4'h0;
        if (w[15]) begin
          case (wa)
            A_GOFF: r_d.cfg.goff = 13'(wb({3'b000, r_q.cfg.goff}, w[8], w[7:0]));
            A_XOFF: r_d.cfg.xoff = 12'(wb({4'h0, r_q.cfg.xoff}, w[8], w[7:0]));
            A_YOFF: r_d.cfg.yoff = 12'(wb({4'h0, r_q.cfg.yoff}, w[8], w[7:0]));
            A_ZOFF: r_d.cfg.zoff = 12'(wb({4'h0, r_q.cfg.zoff}, w[8], w[7:0]));
            A_DAC:  r_d.dac      = 12'(wb({4'h0, r_q.dac}, w[8], w[7:0]));
            A_MISC: r_d.cfg.misc = wb(r_q.cfg.misc, w[8], w[7:0]);
            A_SMPL: r_d.cfg.smpl = w[8] ? r_q.cfg.smpl : w[7:0];
            A_SLP: begin
              r_d.slp    = 9'(wb({7'h00, r_q.slp}, w[8], w[7:0]));
              r_d.slp_go = 1'b1;
            end
            A_CMD: begin
              if (!w[8]) begin
                r_d.cmd = r_d.cmd | w[7:0];
              end
            end
            default: r_d.cmd = r_d.cmd;
          endcase
        end else if ({ra[6:1], 1'b0} == A_CMD) begin
          r_d.tx    = rd(blist(4'h0), r_q, fe_i.diag);
          r_d.burst = 4'h1;
          rdo       = 1'b1;
        end else begin
          r_d.tx = rd(ra, r_q, fe_i.diag);
          rdo    = is_out(ra);
        end
      end
    end

    r_d.nd   = (r_q.nd & ~rdo & ~zero) | upd;
    r_d.oe_n = r_d.cs_acc;
    r_d.lp   = (r_d.cfg.smpl >= LOWPWR_MIN);
    r_d.offl = (r_d.st != ST_RUN);
    r_d.sl   = (r_d.st == ST_SLEEP);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      r_q        <= '0;
      r_q.cs_s   <= 3'h7;
      r_q.cs_acc <= 1'b1;
      r_q.tg_s   <= 3'h7;
      r_q.tg_acc <= 1'b1;
      r_q.st     <= ST_START;
      r_q.ms     <= 17'(STARTUP_MS);
      r_q.cfg    <= CFG_RST;
      r_q.fl     <= CFG_RST;
      r_q.oe_n   <= 1'b1;
      r_q.offl   <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign miso_oe_n_o = r_q.oe_n;
  assign dac_level_o = r_q.dac_in;
  assign low_power_o = r_q.lp;
  assign sleeping_o  = r_q.sl;
  assign offline_o   = r_q.offl;

endmodule : isdc_core

/* File: verification/isdc_core_assertions.sv */
`timescale 1ns/10ps
module isdc_core_assertions
  import isdc_pkg::*;
#(
  parameter int unsigned BASE_FAST_CYCLES = 20,
  parameter int unsigned BASE_SLOW_CYCLES = 60,
  parameter int unsigned MS_CYCLES        = 50,
  parameter int unsigned STARTUP_MS       = 1
) (
  input wire logic                  clk_i,
  input wire logic                  reset_i,
  input wire logic                  sclk_i,
  input wire logic                  cs_n_i,
  input wire logic                  mosi_i,
  input wire isdc_pkg::isdc_front_t fe_i,
  input wire logic                  miso_o,
  input wire logic                  miso_oe_n_o,
  input wire logic [11:0]           dac_level_o,
  input wire logic                  low_power_o,
  input wire logic                  sleeping_o,
  input wire logic                  offline_o
);
  logic [31:0] up_q;
  always_ff @(posedge clk_i) begin
    if (reset_i) up_q <= 32'h0;
    else if (up_q < 32'hFFFF) up_q <= up_q + 32'h1;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  sequence s_wake; sleeping_o ##1 $fell(cs_n_i); endsequence
  sequence s_sclk_high; sclk_i && $past(sclk_i); endsequence
  property p_rst_vals;
    $fell(reset_i) |-> offline_o && !sleeping_o && dac_level_o == 12'h000 && !low_power_o;
  endproperty
  property p_startup; (up_q < STARTUP_MS * MS_CYCLES - 2) |-> offline_o; endproperty
  property p_sleep_off; sleeping_o |-> offline_o; endproperty
  property p_wake; s_wake |-> ##[1:10] !sleeping_o; endproperty
  property p_sleep_start; $rose(sleeping_o) |-> cs_n_i; endproperty
  property p_lp_frame; $changed(low_power_o) |-> cs_n_i; endproperty
  property p_dac_frame; $changed(dac_level_o) |-> cs_n_i; endproperty
  property p_miso_hold; s_sclk_high |-> $stable(miso_o); endproperty
  property p_oe_on; !cs_n_i [*6] |-> !miso_oe_n_o; endproperty
  property p_oe_off; cs_n_i [*6] |-> miso_oe_n_o; endproperty
  a_rst_vals: assert property (p_rst_vals) else $error("bad outputs after reset");
  a_startup: assert property (p_startup) else $error("online during start-up");
  a_sleep_off: assert property (p_sleep_off) else $error("asleep but online");
  a_wake: assert property (p_wake) else $error("no wake on select");
  a_sleep_start: assert property (p_sleep_start) else $error("sleep inside frame");
  a_lp_frame: assert property (p_lp_frame) else $error("power mode moved in frame");
  a_dac_frame: assert property (p_dac_frame) else $error("dac moved in frame");
  a_miso_hold: assert property (p_miso_hold) else $error("miso moved, clock high");
  a_oe_on: assert property (p_oe_on) else $error("miso not driven");
  a_oe_off: assert property (p_oe_off) else $error("miso driven idle");
endmodule : isdc_core_assertions

bind isdc_core isdc_core_assertions #(
  .BASE_FAST_CYCLES(BASE_FAST_CYCLES), .BASE_SLOW_CYCLES(BASE_SLOW_CYCLES),
  .MS_CYCLES(MS_CYCLES), .STARTUP_MS(STARTUP_MS)
) u_chk (.clk_i, .reset_i, .sclk_i, .cs_n_i, .mosi_i, .fe_i, .miso_o, .miso_oe_n_o,
  .dac_level_o, .low_power_o, .sleeping_o, .offline_o);

/* File: verification/isdc_spi_host.sv */
`timescale 1ns/10ps
module isdc_spi_host (
  output logic        sclk_o,
  output logic        cs_n_o,
  output logic        mosi_o,
  input  wire logic   miso_i,
  output logic [15:0] rx_word_o,
  output logic        rx_stb_o
);
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
    rx_word_o = 16'h0000;
    rx_stb_o = 1'b0;
    // one idle clock with select high clears the link's bit counter
    #10 sclk_o = 1'b0;
    #40 sclk_o = 1'b1;
  end
  // mode 3 frame, msb first, clock still outside frames
  task automatic xfer(input logic [15:0] tx);
    #3 cs_n_o = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #40 sclk_o = 1'b0;
      mosi_o = tx[i];
      #40 sclk_o = 1'b1;
      rx_word_o[i] = miso_i;
    end
    #20 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    rx_stb_o = 1'b1;
    #10 rx_stb_o = 1'b0;
    #120;
  endtask : xfer
endmodule : isdc_spi_host

/* File: verification/testbench.sv */
`timescale 1ns/10ps
module testbench;
  import isdc_pkg::*;
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        sclk, cs_n, mosi, miso_d, miso_w, miso_oe_n, rx_stb;
  logic        low_power, sleeping, offline;
  logic        miso_hold = 1'b0;
  isdc_front_t fe;
  logic [15:0] rx;
  logic [11:0] dac, xo, yo, zo;
  logic [12:0] go;
  logic [32:0] exp_q[$];
  int          num_errors = 0;
  int          samples_checked = 0;
  int          cyc = 0;

  always #2.5 clk_i = ~clk_i;
  always @(miso_d) if (!miso_oe_n) miso_hold = miso_d;
  assign miso_w = miso_oe_n ? ~miso_hold : miso_d;

  isdc_core #(.BASE_FAST_CYCLES(20), .BASE_SLOW_CYCLES(120), .MS_CYCLES(50), .STARTUP_MS(1)) dut (
    .clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .fe_i(fe),
    .miso_o(miso_d), .miso_oe_n_o(miso_oe_n), .dac_level_o(dac), .low_power_o(low_power),
    .sleeping_o(sleeping), .offline_o(offline));
  isdc_spi_host host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w),
    .rx_word_o(rx), .rx_stb_o(rx_stb));

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  task automatic stop_test;
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : stop_test
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : w
  task automatic w_run(input int lim);
    for (int i = 0; i < lim && offline !== 1'b0; i++) w(1);
    cmp({15'h0, offline}, 16'h0000);
  endtask : w_run
  task automatic fr(input logic [15:0] tx, input logic [32:0] e);
    exp_q.push_back(e);
    host.xfer(tx);
    w(1);
  endtask : fr
  task automatic wr8(input logic [6:0] a, input logic [7:0] d);
    fr({2'b10, a[5:0], d}, 33'h0);
  endtask : wr8
  task automatic wr16(input logic [6:0] a, input logic [15:0] d);
    wr8(a, d[7:0]);
    wr8(a | 7'h01, d[15:8]);
  endtask : wr16
  task automatic rd(input logic [6:0] a, input logic [15:0] e, input logic [15:0] m);
    fr({1'b0, a, 8'h00}, 33'h0);
    fr(16'h0000, {1'b1, m, e});
  endtask : rd
  function automatic logic [15:0] ow(input logic [13:0] d);
    return {1'b0, |fe.diag, d};
  endfunction : ow
  function automatic logic [13:0] rate_x(input int rs, input logic lc);
    int r;
    r = ($signed(fe.rate) <<< rs) + ($signed(go) >>> (2 - rs)) - (lc ? $signed(fe.lin_corr) : 0);
    return r[13:0];
  endfunction : rate_x
  task automatic burst(input int rs, input logic lc);
    logic [13:0] d[9];
    d = '{{2'b00, fe.supply}, rate_x(rs, lc), fe.ax + {{2{xo[11]}}, xo},
          fe.ay + {{2{yo[11]}}, yo}, fe.az + {{2{zo[11]}}, zo}, {{2{fe.temp[11]}}, fe.temp},
          {fe.pitch[12], fe.pitch}, {fe.roll[12], fe.roll}, {2'b00, fe.aux}};
    fr(16'h3E00, 33'h0);
    foreach (d[i]) fr(16'h0000, {1'b1, 16'h7FFF, ow(d[i])});
  endtask : burst

  always @(posedge rx_stb) begin : mon
    logic [32:0] e;
    if (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e[32]) cmp(rx & e[31:16], e[15:0] & e[31:16]);
    end
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 99000) begin
      num_errors++;
      stop_test();
    end
  end

  initial begin : main
    logic [159:0] rnd;
    logic [13:0]  r;
    logic [11:0]  dv;
    void'($urandom(96510));
    rnd = {$urandom, $urandom, $urandom, $urandom, $urandom};
    fe = rnd[149:0];
    w(20);
    cmp({dac, low_power, sleeping, offline, miso_oe_n}, 16'h0003);
    reset_i = 1'b0;
    w_run(200);
    rd(A_SMPL, 16'h0001, 16'h00FF);
    rd(A_MISC, MISC_RST, 16'hFFFF);
    rd(A_XOFF, 16'h0000, 16'h0FFF);
    rd(7'h06, 16'h0000, 16'hFFFF);
    for (int v = 9; v < 11; v++) begin
      wr8(A_SMPL, 8'(v));
      w(20);
      cmp({15'h0, low_power}, {15'h0, v > 9});
    end
    go = 13'($urandom);
    xo = 12'($urandom);
    yo = 12'($urandom);
    zo = 12'($urandom);
    wr16(A_GOFF, {3'b000, go});
    wr16(A_XOFF, {4'h0, xo});
    wr16(A_YOFF, {4'h0, yo});
    wr16(A_ZOFF, {4'h0, zo});
    wr8(A_SMPL, 8'h01);
    for (int rs = 0; rs < 3; rs++) begin
      fe.range_sel = 2'(rs);
      fe.diag = (rs == 2) ? 16'h0000 : 16'($urandom | 1);
      wr8(A_MISC, (rs == 1) ? 8'h06 : 8'h86);
      w(200);
      burst(rs, rs != 1);
    end
    wr8(A_SMPL, 8'hFF);
    fr({1'b0, A_XACC, 8'h00}, 33'h0);
    rd(A_XACC, 16'h0000, 16'h8000);
    w(15500);
    rd(A_XACC, 16'h8000, 16'h8000);
    dv = 12'($urandom);
    wr8(A_DAC, dv[7:0]);
    wr8(A_DAC | 7'h01, {4'h0, dv[11:8]});
    cmp({4'h0, dac}, 16'h0000);
    wr8(A_CMD, 8'h04);
    w(20);
    cmp({4'h0, dac}, {4'h0, dv});
    wr8(A_CMD, 8'h80);
    w_run(400);
    cmp({15'h0, low_power}, 16'h0000);
    rd(A_XOFF, 16'h0000, 16'h0FFF);
    r = 14'($urandom_range(999)) - 14'd500;
    fe.rate = r;
    fe.range_sel = 2'd0;
    w(200);
    wr8(A_CMD, 8'h01);
    w_run(4000);
    go = 13'(-4 * $signed(r));
    rd(A_GOFF, {3'b000, go}, 16'h1FFF);
    rd(A_GYRO, 16'h0000, 16'h3FFF);
    wr16(A_XOFF, 16'h0555);
    wr8(A_CMD, 8'h02);
    w_run(4000);
    rd(A_XOFF, 16'h0000, 16'h0FFF);
    rd(A_GOFF, 16'h0000, 16'h1FFF);
    wr8(A_SMPL, 8'h0A);
    wr8(A_CMD, 8'h08);
    w(3000);
    wr8(A_CMD, 8'h80);
    w_run(400);
    cmp({15'h0, low_power}, 16'h0001);
    wr8(A_SLP, 8'h01);
    w(20);
    cmp({15'h0, sleeping}, 16'h0001);
    w(24000);
    cmp({15'h0, sleeping}, 16'h0001);
    w(2000);
    cmp({15'h0, sleeping}, 16'h0000);
    wr8(A_SLP | 7'h01, 8'h01);
    w(520);
    cmp({15'h0, sleeping}, 16'h0001);
    fr(16'h0000, 33'h0);
    w(20);
    cmp({15'h0, sleeping}, 16'h0000);
    stop_test();
  end
endmodule : testbench
